// >>> src/rofm_consts.vh
// Purpose: Offsets, field positions and reset values for the rail override and fault mask bank
// Assumes: Included by bare name from the design files
// Notes:   Reset values stand in for factory-programmed defaults
`ifndef ROFM_CONSTS_VH
`define ROFM_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ROFM_OFS_OVERRIDE_FIRST   8'ha0
`define ROFM_OFS_OVERRIDE_LEVEL   8'ha1
`define ROFM_OFS_FAULT_MASK_FIRST 8'ha2

// ****************************************************************
// Field positions
// ****************************************************************
`define ROFM_BIT_LDO_TWO      7
`define ROFM_BIT_SWITCH_A     6
`define ROFM_BIT_TERMINATION  3
`define ROFM_BIT_SWITCH_B2    2
`define ROFM_BIT_SWITCH_B1    1
`define ROFM_BIT_LDO_THREE    0
`define ROFM_BIT_OUT_FOUR     7
`define ROFM_BIT_OUT_THREE    6
`define ROFM_BIT_OUT_TWO      5
`define ROFM_BIT_OUT_ONE      4

// ****************************************************************
// Reset values
// ****************************************************************
`define ROFM_RST_OVERRIDE_FIRST   8'h00
`define ROFM_RST_OVERRIDE_LEVEL   8'h10
`define ROFM_RST_FAULT_MASK_FIRST 8'hc0

`endif

// >>> src/rofm_reg8.v
// Purpose: One 8-bit read/write register with a per-bit write mask
// Assumes: Synchronous active-low reset on core_clk
// Notes:   Read data come straight from the flip-flops
`timescale 1ns/100ps

module rofm_reg8 #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       wr_en,
  input  wire [7:0] wr_mask,
  input  wire [7:0] wr_data,
  output reg  [7:0] q
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Masked bits keep their old value so ignored writes leave no trace
  always @(posedge core_clk) begin
    if (!nrst) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= (q & ~wr_mask) | (wr_data & wr_mask);
    end
  end

endmodule

// >>> src/rofm_regs.v
// Contract
// R01: Override clear: rail follows pin or power-good
// R02: Override set forces rail on, unless disabled
// R03: Disable bit zero turns rail off, wins
// R04: First override: ldo two, switch a, stepdowns
// R05: Second override: termination, switch b2, b1, ldo3
// R06: Output level bit drives pin low/high
// R07: Output four level only when open-drain
// R08: Output three, two, one levels at bits 6-4
// R09: Unused output level bits ignore writes
// R10: Unmasked rail fault shuts device down
// R11: First fault mask: ldo two, switch a, stepdowns
// R12: Offsets a1h and a2h, read/write, factory reset
// R13: Enable equals request or override, and disable
//
// Purpose: Rail override, general output level and fault mask register bank
// Assumes: Serial-bus engine outside gives decoded byte writes and reads on core_clk
// Notes:   Pin requests, power-good and fault inputs come from other clock domains
//          Level bits of pins that cannot drive are write protected
//          A latched shutdown only clears through nrst
`timescale 1ns/100ps
`include "rofm_consts.vh"

module rofm_regs #(
  parameter [3:0] OUT_IS_OUTPUT    = 4'hf,
  parameter [3:0] OUT_IS_OPEN_DRN  = 4'h8
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_hit,
  input  wire [7:0]  rail_request_first,
  input  wire [3:0]  rail_request_second,
  input  wire [7:0]  rail_disable_n_first,
  input  wire [3:0]  rail_disable_n_second,
  input  wire [7:0]  rail_fault_first,
  output reg  [7:0]  rail_enable_first,
  output reg  [3:0]  rail_enable_second,
  output reg  [3:0]  general_output_o,
  output reg  [3:0]  general_output_oe,
  output reg         shutdown_request
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Register select codes; zero means the address hit nothing
  localparam [1:0] SEL_NONE       = 2'h0;
  localparam [1:0] SEL_OVERRIDE   = 2'h1;
  localparam [1:0] SEL_LEVEL      = 2'h2;
  localparam [1:0] SEL_FAULT_MASK = 2'h3;

  // Factory pin modes of the general outputs
  localparam [1:0] PIN_UNUSED     = 2'h0;
  localparam [1:0] PIN_OPEN_DRAIN = 2'h1;
  localparam [1:0] PIN_PUSH_PULL  = 2'h2;

  // Shared by write strobes and read mux
  function [1:0] rofm_decode;
    input [7:0] addr;
    begin
      case (addr)
        `ROFM_OFS_OVERRIDE_FIRST:   rofm_decode = SEL_OVERRIDE;
        `ROFM_OFS_OVERRIDE_LEVEL:   rofm_decode = SEL_LEVEL; // see R12
        `ROFM_OFS_FAULT_MASK_FIRST: rofm_decode = SEL_FAULT_MASK; // see R12
        default:                    rofm_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Shared by write protection and pin drivers, so both agree on each pin
  // Output four can only pull low, so a push-pull setting there leaves it unused
  function [1:0] rofm_pin_mode;
    input integer idx;
    begin
      if (!OUT_IS_OUTPUT[idx]) begin
        rofm_pin_mode = PIN_UNUSED;
      end else if (OUT_IS_OPEN_DRN[idx]) begin
        rofm_pin_mode = PIN_OPEN_DRAIN;
      end else if (idx == 3) begin
        rofm_pin_mode = PIN_UNUSED; // see R07
      end else begin
        rofm_pin_mode = PIN_PUSH_PULL;
      end
    end
  endfunction

  wire [1:0] sel;
  wire [7:0] override_first;
  wire [7:0] override_level;
  wire [7:0] fault_mask_first;
  wire [7:0] level_wr_mask;
  wire [3:0] level_keep;
  wire       wr_override_first;
  wire       wr_override_level;
  wire       wr_fault_mask_first;

  assign sel = rofm_decode(reg_addr);

  // One strobe per register; a miss strobes none, so unmapped writes vanish
  assign wr_override_first   = reg_wr && (sel == SEL_OVERRIDE);
  assign wr_override_level   = reg_wr && (sel == SEL_LEVEL);
  assign wr_fault_mask_first = reg_wr && (sel == SEL_FAULT_MASK);

  // Level bits of pins that cannot drive refuse writes
  genvar m;
  generate
    for (m = 0; m < 4; m = m + 1) begin : gen_keep
      assign level_keep[m] = (rofm_pin_mode(m) != PIN_UNUSED); // see R09
    end
  endgenerate

  // Override nibble is always writable
  assign level_wr_mask = {level_keep, 4'hf}; // see R09

  // ****************************************************************
  // Registers
  // ****************************************************************
  // First override: bit 7 ldo two, bit 6 switch a, bits 5-0 stepdowns
  rofm_reg8 #(
    .RESET_VALUE (`ROFM_RST_OVERRIDE_FIRST)
  ) u_override_first (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_en    (wr_override_first), // see R04
    .wr_mask  (8'hff),
    .wr_data  (reg_wdata),
    .q        (override_first)
  );

  // Combined register: output levels high nibble, overrides low nibble
  rofm_reg8 #(
    .RESET_VALUE (`ROFM_RST_OVERRIDE_LEVEL)
  ) u_override_level (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_en    (wr_override_level), // see R05
    .wr_mask  (level_wr_mask),
    .wr_data  (reg_wdata),
    .q        (override_level)
  );

  // Fault mask: bit 7 ldo two, bit 6 switch a, bits 5-0 stepdowns
  rofm_reg8 #(
    .RESET_VALUE (`ROFM_RST_FAULT_MASK_FIRST)
  ) u_fault_mask_first (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_en    (wr_fault_mask_first), // see R11
    .wr_mask  (8'hff),
    .wr_data  (reg_wdata),
    .q        (fault_mask_first)
  );

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins and analog comparators are asynchronous; two stages each
  reg [31:0] sync_meta;
  reg [31:0] sync_q;
  wire [31:0] sync_in;

  assign sync_in = {rail_request_first, rail_request_second, rail_disable_n_first,
                    rail_disable_n_second, rail_fault_first};

  always @(posedge core_clk) begin
    if (!nrst) begin
      sync_meta <= 32'h00000000;
      sync_q    <= 32'h00000000;
    end else begin
      sync_meta <= sync_in;
      sync_q    <= sync_meta;
    end
  end

  wire [7:0] req_first;
  wire [3:0] req_second;
  wire [7:0] dis_n_first;
  wire [3:0] dis_n_second;
  wire [7:0] fault_first;

  assign req_first    = sync_q[31:24];
  assign req_second   = sync_q[23:20];
  assign dis_n_first  = sync_q[19:12];
  assign dis_n_second = sync_q[11:8];
  assign fault_first  = sync_q[7:0];

  // ****************************************************************
  // Rail enables
  // ****************************************************************
  // Override forces on, the disable input has the last word
  wire [7:0] next_enable_first;
  wire [3:0] next_enable_second;
  wire [3:0] override_second;

  assign override_second    = override_level[`ROFM_BIT_TERMINATION:`ROFM_BIT_LDO_THREE]; // see R05
  assign next_enable_first  = (req_first | override_first) & dis_n_first; // see R13
  assign next_enable_second = (req_second | override_second) & dis_n_second; // see R13

  // Re-evaluated every cycle, so a write takes effect the next edge
  always @(posedge core_clk) begin
    if (!nrst) begin
      rail_enable_first  <= 8'h00;
      rail_enable_second <= 4'h0;
    end else begin
      rail_enable_first  <= next_enable_first; // see R01 see R02 see R03
      rail_enable_second <= next_enable_second; // see R01 see R02 see R03
    end
  end

  // ****************************************************************
  // General outputs
  // ****************************************************************
  // Open-drain pins only pull low and leave the high level to the pull-up
  wire [3:0] level_bits;
  wire [3:0] next_out;
  wire [3:0] next_oe;

  assign level_bits = override_level[`ROFM_BIT_OUT_FOUR:`ROFM_BIT_OUT_ONE]; // see R08

  // Unused pins stay released whatever their level bit holds
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : gen_pin
      wire [1:0] mode;
      assign mode = rofm_pin_mode(p);
      // Push-pull follows the level; open-drain sinks only for a zero
      assign next_out[p] = (mode == PIN_PUSH_PULL) ? level_bits[p] : 1'b0; // see R06
      assign next_oe[p]  = (mode == PIN_PUSH_PULL) ? 1'b1 :
                           ((mode == PIN_OPEN_DRAIN) & ~level_bits[p]); // see R06 see R07
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!nrst) begin
      general_output_o  <= 4'h0;
      general_output_oe <= 4'h0;
    end else begin
      general_output_o  <= next_out;
      general_output_oe <= next_oe;
    end
  end

  // ****************************************************************
  // Fault shutdown
  // ****************************************************************
  // A masked rail may fault freely; any other first-group rail trips the device
  wire [7:0] fault_live;

  assign fault_live = fault_first & ~fault_mask_first; // see R11

  // Sticky until reset: a shutdown must not release by itself
  always @(posedge core_clk) begin
    if (!nrst) begin
      shutdown_request <= 1'b0;
    end else if (|fault_live) begin
      shutdown_request <= 1'b1; // see R10
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Unmapped addresses read zero and drop reg_hit
  reg [7:0] next_rdata;
  reg       next_hit;

  always @* begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    case (sel)
      SEL_OVERRIDE: begin
        next_rdata = override_first;
        next_hit   = 1'b1;
      end
      SEL_LEVEL: begin
        next_rdata = override_level;
        next_hit   = 1'b1;
      end
      SEL_FAULT_MASK: begin
        next_rdata = fault_mask_first;
        next_hit   = 1'b1;
      end
      default: begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
      end
    endcase
  end

  // A write also loads the old value, which the host may simply ignore
  always @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else if (reg_rd || reg_wr) begin
      reg_hit   <= next_hit; // see R12
      reg_rdata <= next_rdata;
    end
  end

endmodule

// >>> dv/rofm_regs_assertions.sv
// Purpose: Port checks for rofm_regs
// Assumes: Output configuration taken from the bound instance
// Notes:   Bound below the module
`timescale 1ns/100ps
module rofm_regs_assertions #(
  parameter [3:0] OUT_IS_OUTPUT   = 4'hf,
  parameter [3:0] OUT_IS_OPEN_DRN = 4'h8
) (
  input wire       core_clk,
  input wire       nrst,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       reg_hit,
  input wire [7:0] rail_request_first,
  input wire [3:0] rail_request_second,
  input wire [7:0] rail_disable_n_first,
  input wire [3:0] rail_disable_n_second,
  input wire [7:0] rail_fault_first,
  input wire [7:0] rail_enable_first,
  input wire [3:0] rail_enable_second,
  input wire [3:0] general_output_o,
  input wire [3:0] general_output_oe,
  input wire       shutdown_request
);
  // Push-pull outputs whose level bit reaches the pin
  localparam [2:0] PP = OUT_IS_OUTPUT[2:0] & ~OUT_IS_OPEN_DRN[2:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ****************
  // Properties
  // ****************
  sequence s_wr_a1; reg_wr && reg_addr == 8'ha1; endsequence
  sequence s_dis_up; (rail_disable_n_first == 8'hff)[*4] ##0 reg_wr && reg_addr == 8'ha0; endsequence
  // Mask cleared, then a fault held with no rewrite of the mask
  sequence s_unmask;
    reg_wr && reg_addr == 8'ha2 && reg_wdata == 8'h00 ##1 (rail_fault_first != 8'h00 && !reg_wr)[*4];
  endsequence
  property p_hit; reg_wr || reg_rd |=> reg_hit == ($past(reg_addr) inside {8'ha0, 8'ha1, 8'ha2}); endproperty
  a_hit: assert property (p_hit) else $error("hit flag wrong");
  property p_unmap; (reg_wr || reg_rd) && !(reg_addr inside {8'ha0, 8'ha1, 8'ha2}) |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dis; (rail_disable_n_first == 8'h00)[*4] |=> rail_enable_first == 8'h00; endproperty
  a_dis: assert property (p_dis) else $error("disabled rail on");
  property p_force; s_dis_up |=> ##1 (rail_enable_first & $past(reg_wdata, 2)) == $past(reg_wdata, 2); endproperty
  a_force: assert property (p_force) else $error("override not forcing");
  property p_pp; s_wr_a1 |=> ##1 (general_output_o[2:0] & PP) == ($past(reg_wdata[6:4], 2) & PP); endproperty
  a_pp: assert property (p_pp) else $error("output level wrong");
  property p_od4;
    s_wr_a1 |=> ##1 general_output_oe[3] == (OUT_IS_OUTPUT[3] & OUT_IS_OPEN_DRN[3] & !$past(reg_wdata[7], 2));
  endproperty
  a_od4: assert property (p_od4) else $error("output four drive wrong");
  property p_src;
    $rose(shutdown_request) |-> ($past(rail_fault_first, 2) | $past(rail_fault_first, 3)
      | $past(rail_fault_first, 4)) != 8'h00;
  endproperty
  a_src: assert property (p_src) else $error("shutdown without fault");
  property p_unmask; s_unmask |=> shutdown_request; endproperty
  a_unmask: assert property (p_unmask) else $error("unmasked fault ignored");
endmodule

bind rofm_regs rofm_regs_assertions #(
  .OUT_IS_OUTPUT   (OUT_IS_OUTPUT),
  .OUT_IS_OPEN_DRN (OUT_IS_OPEN_DRN)
) i_chk (
  .core_clk              (core_clk),
  .nrst                  (nrst),
  .reg_wr                (reg_wr),
  .reg_rd                (reg_rd),
  .reg_addr              (reg_addr),
  .reg_wdata             (reg_wdata),
  .reg_rdata             (reg_rdata),
  .reg_hit               (reg_hit),
  .rail_request_first    (rail_request_first),
  .rail_request_second   (rail_request_second),
  .rail_disable_n_first  (rail_disable_n_first),
  .rail_disable_n_second (rail_disable_n_second),
  .rail_fault_first      (rail_fault_first),
  .rail_enable_first     (rail_enable_first),
  .rail_enable_second    (rail_enable_second),
  .general_output_o      (general_output_o),
  .general_output_oe     (general_output_oe),
  .shutdown_request      (shutdown_request)
);

// >>> dv/rofm_host.sv
// Purpose: Serial host side, single byte accesses
// Assumes: Strobe sampled at one rising edge
// Notes:   Idle bus shows inverted values
`timescale 1ns/100ps
module rofm_host (
  input  wire        core_clk,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Inverting on release so no stale byte looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge core_clk);
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule

// >>> dv/test_rofm_regs.sv
// Purpose: Bench for rofm_regs
// Assumes: Output three unused, outputs two and four open-drain, output one push-pull
// Notes:   Read answers are checked one edge after the strobe is taken
`timescale 1ns/100ps
module test_rofm_regs;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       reg_wr, reg_rd, reg_hit, shutdown_request;
  logic       rd_seen = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rail_enable_first, d, g;
  logic [7:0] rail_request_first = 8'h00, rail_disable_n_first = 8'hff, rail_fault_first = 8'h00;
  logic [3:0] rail_request_second = 4'h0, rail_disable_n_second = 4'hf;
  logic [3:0] rail_enable_second, general_output_o, general_output_oe;
  logic [8:0] exp_q[$];
  int         err_total = 0, checks_done = 0, seed = 58479, cyc = 0;
  rofm_host i_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  // Every pin mode is present, so write protection and both drive styles are reached
  rofm_regs #(.OUT_IS_OUTPUT(4'hb), .OUT_IS_OPEN_DRN(4'ha)) i_dut (.core_clk, .nrst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_hit,
    .rail_request_first, .rail_request_second, .rail_disable_n_first, .rail_disable_n_second,
    .rail_fault_first, .rail_enable_first, .rail_enable_second, .general_output_o,
    .general_output_oe, .shutdown_request);
  // Clock and a ceiling well above the run length
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 1000) begin
    err_total++;
    end_of_test;
  end
  task automatic chk_lvl(input string n, input logic [8:0] e, input logic [8:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_read(input logic [8:0] e, input logic [8:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] read expected %h seen %h", e, s);
    end
  endtask
  // The answer stands from the edge that takes the strobe, so look half a cycle later
  always @(posedge core_clk) rd_seen <= (reg_rd === 1'b1);
  // Read answers are compared against the oldest note
  always @(negedge core_clk) if (rd_seen) chk_read(exp_q.pop_front(), {reg_hit, reg_rdata});
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    exp_q.push_back({h, e});
    i_host.xfer(1'b0, a, $random(seed));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(3);
    nrst = 1'b1;
    rd(8'ha0, 8'h00, 1'b1);
    rd(8'ha1, 8'h10, 1'b1);
    rd(8'ha2, 8'hc0, 1'b1);
    rd(8'h5a, 8'h00, 1'b0);
    repeat (6) begin
      d = $random(seed);
      g = $random(seed);
      i_host.xfer(1'b1, 8'ha0, d);
      i_host.xfer(1'b1, 8'ha1, g);
      rd(8'ha0, d, 1'b1);
      rd(8'ha1, {g[7], 1'b0, g[5:0]}, 1'b1);
      {rail_request_first, rail_disable_n_first} = $random(seed);
      {rail_request_second, rail_disable_n_second} = $random(seed);
      tick(5);
      chk_lvl("en_a", {1'b0, (rail_request_first | d) & rail_disable_n_first}, {1'b0, rail_enable_first});
      chk_lvl("en_b", {5'h0, (rail_request_second | g[3:0]) & rail_disable_n_second}, {5'h0, rail_enable_second});
      chk_lvl("gpo", {1'b0, 3'h0, g[4], ~g[7], 1'b0, ~g[5], 1'b1}, {1'b0, general_output_o, general_output_oe});
    end
    rail_disable_n_first = 8'h00;
    tick(5);
    chk_lvl("en_off", 9'h000, {1'b0, rail_enable_first});
    i_host.xfer(1'b1, 8'ha2, 8'hfe);
    rail_fault_first = 8'hfe;
    tick(5);
    chk_lvl("shut_mask", 9'h000, {8'h00, shutdown_request});
    i_host.xfer(1'b1, 8'ha2, 8'h00);
    tick(5);
    chk_lvl("shut_on", 9'h001, {8'h00, shutdown_request});
    nrst = 1'b0;
    rail_fault_first = 8'h00;
    tick(3);
    nrst = 1'b1;
    chk_lvl("shut_rst", 9'h000, {8'h00, shutdown_request});
    rd(8'ha2, 8'hc0, 1'b1);
    tick(2);
    end_of_test;
  end
endmodule
